/* File: clpt_pkg.sv */
/*
 Constants, register map and carrier types of the cold load pick-up timing block.
 Assumes one 25 MHz processing clock and currents scaled in hundredths of nominal.
*/
package clpt_pkg;

   // Clock and timer resolution
   localparam int CLK_NS = 40;
   localparam int TICK_NS = 5000000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int TICK_MS = 5;

   // Widths
   localparam int CUR_W = 16;
   localparam int TIMER_W = 20;
   localparam int MW = CUR_W + 7;
   localparam int NUM_EV = 6;
   localparam int REC_DEPTH = 12;
   localparam int REC_AW = 4;

   // Hysteresis ratio, percent of setting
   localparam logic [MW-1:0] PCT_FULL = 23'h000064;
   localparam logic [MW-1:0] PCT_REL = 23'h000061;

   // Setting defaults
   localparam int START_DELAY_MS = 10000;
   localparam int MAX_INRUSH_MS = 30000;
   localparam int MIN_HOLD_MS = 40;
   localparam logic [TIMER_W-1:0] START_DEF = TIMER_W'(START_DELAY_MS / TICK_MS);
   localparam logic [TIMER_W-1:0] MAX_DEF = TIMER_W'(MAX_INRUSH_MS / TICK_MS);
   localparam logic [TIMER_W-1:0] MIN_DEF = TIMER_W'(MIN_HOLD_MS / TICK_MS);
   localparam logic [CUR_W-1:0] LOW_DEF = 16'h0014;
   localparam logic [CUR_W-1:0] HIGH_DEF = 16'h0078;
   localparam logic [CUR_W-1:0] OVER_DEF = 16'h00c8;
   localparam logic [NUM_EV-1:0] MASK_DEF = 6'h3f;

   // Event identifiers
   localparam int EV_LOW = 0;
   localparam int EV_HIGH = 1;
   localparam int EV_NORMAL = 2;
   localparam int EV_OVER = 3;
   localparam int EV_PICKUP = 4;
   localparam int EV_BLOCK = 5;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] LOW_THR_OFS = 8'h04;
   localparam logic [7:0] HIGH_THR_OFS = 8'h08;
   localparam logic [7:0] OVER_THR_OFS = 8'h0c;
   localparam logic [7:0] START_OFS = 8'h10;
   localparam logic [7:0] MAX_OFS = 8'h14;
   localparam logic [7:0] MIN_OFS = 8'h18;
   localparam logic [7:0] EVMASK_OFS = 8'h1c;
   localparam logic [7:0] STATUS_OFS = 8'h20;
   localparam logic [7:0] ACT_CNT_OFS = 8'h24;
   localparam logic [7:0] BLK_CNT_OFS = 8'h28;
   localparam logic [7:0] REC_SEL_OFS = 8'h2c;
   localparam logic [7:0] REC_PTR_OFS = 8'h30;
   localparam logic [7:0] REC_TS_OFS = 8'h34;
   localparam logic [7:0] REC_ID_OFS = 8'h38;
   localparam logic [7:0] REC_I12_OFS = 8'h3c;
   localparam logic [7:0] REC_I3_OFS = 8'h40;
   localparam logic [7:0] REC_TTA_OFS = 8'h44;
   localparam logic [7:0] REC_ACT_OFS = 8'h48;
   localparam logic [7:0] REC_START_OFS = 8'h4c;
   localparam logic [7:0] REC_RECL_OFS = 8'h50;
   localparam int CTRL_CLR_BIT = 0;
   localparam int EVMASK_OFF_LSB = 8;

   typedef struct packed {
      logic [2:0][CUR_W-1:0] mag;
   } clpt_phase_t;

   typedef struct packed {
      logic [NUM_EV-1:0] on;
      logic [NUM_EV-1:0] off;
      logic [31:0] stamp;
   } clpt_event_t;

   typedef struct packed {
      logic [31:0] stamp;
      logic [2:0] id;
      logic [2:0] group;
      logic [2:0][CUR_W-1:0] mag;
      logic [TIMER_W-1:0] to_act;
      logic [TIMER_W-1:0] act_time;
      logic [TIMER_W-1:0] startup;
      logic [TIMER_W-1:0] reclaim;
   } clpt_rec_t;

endpackage : clpt_pkg

/* File: clpt_cold_load_pickup.sv */
/*
 Cold load pick-up detector: comparators, start/max/min timers, events, counters,
 a circular store of operation records and an APB register slave.
 Assumes currents, block, setting group and time stamp come from logic on pclk.
*/
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
module clpt_cold_load_pickup #(
   parameter int TICK_CYCLES = clpt_pkg::TICK_CYC,
   parameter int REC_DEPTH = clpt_pkg::REC_DEPTH
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire clpt_pkg::clpt_phase_t measured_magnitude,
   input wire logic block_in,
   input wire logic [2:0] setting_group,
   input wire logic [31:0] time_stamp,
   output logic pickup_active_out,
   output logic blocked_out,
   output clpt_pkg::clpt_event_t event_out
);

   localparam int TW = clpt_pkg::TIMER_W;
   localparam int CW = clpt_pkg::CUR_W;
   localparam int MW = clpt_pkg::MW;
   localparam int NE = clpt_pkg::NUM_EV;
   localparam int AW = clpt_pkg::REC_AW;

   typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_BLOCKED} clpt_state_t;

   clpt_state_t state_reg;
   logic [31:0] tick_cnt_reg;
   logic tick_reg, tick_d_reg;
   logic [CW-1:0] low_thr_reg, high_thr_reg, over_thr_reg;
   logic [TW-1:0] start_delay_reg, max_time_reg, min_time_reg;
   logic [NE-1:0] mask_on_reg, mask_off_reg;
   logic clr_cnt_reg;
   logic [2:0] low_ph_reg, high_ph_reg, over_ph_reg;
   logic low_prev_reg;
   logic [TW-1:0] start_cnt_reg, max_cnt_reg, min_cnt_reg, act_cnt_reg;
   logic max_run_reg, min_run_reg;
   logic [NE-1:0] cond_prev_reg;
   logic [31:0] act_count_reg, blk_count_reg;
   clpt_pkg::clpt_rec_t rec_mem [REC_DEPTH];
   logic [AW-1:0] rec_wptr_reg, rec_sel_reg;
   logic [AW:0] rec_fill_reg;
   logic low_cond, high_cond, over_cond, band_cond, min_done, max_done;
   logic [NE-1:0] cond_vec, rise_vec, fall_vec;
   logic setup_ph, wr_en;
   logic addr_ok;
   logic [31:0] rd_data;
   clpt_pkg::clpt_rec_t rec_rd;

   ////////////////////////////////////////////////////////////////////////////
   // Timer resolution tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= 32'h00000000;
         tick_reg <= 1'b0;
         tick_d_reg <= 1'b0;
      end else begin
         tick_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1));
         tick_d_reg <= tick_reg;
         if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= 32'h00000000;
         end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-phase comparators with hysteresis, sampled once per tick
   for (genvar p = 0; p < 3; p++) begin : g_phase
      logic [MW-1:0] im100, im97, low100, low97, high100, high97, over100, over97;
      assign im100 = MW'(measured_magnitude.mag[p]) * clpt_pkg::PCT_FULL;
      assign im97 = MW'(measured_magnitude.mag[p]) * clpt_pkg::PCT_REL;
      assign low100 = MW'(low_thr_reg) * clpt_pkg::PCT_FULL;
      assign low97 = MW'(low_thr_reg) * clpt_pkg::PCT_REL;
      assign high100 = MW'(high_thr_reg) * clpt_pkg::PCT_FULL;
      assign high97 = MW'(high_thr_reg) * clpt_pkg::PCT_REL;
      assign over100 = MW'(over_thr_reg) * clpt_pkg::PCT_FULL;
      assign over97 = MW'(over_thr_reg) * clpt_pkg::PCT_REL;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            low_ph_reg[p] <= 1'b0;
            high_ph_reg[p] <= 1'b0;
            over_ph_reg[p] <= 1'b0;
         end else if (tick_reg) begin
            // Under-type releases once 97 % of current passes the setting
            if (im100 < low100) begin
               low_ph_reg[p] <= 1'b1;
            end else if (im97 > low100) begin
               low_ph_reg[p] <= 1'b0;
            end
            if (im100 > high100) begin
               high_ph_reg[p] <= 1'b1;
            end else if (im100 < high97) begin
               high_ph_reg[p] <= 1'b0;
            end
            if (im100 > over100) begin
               over_ph_reg[p] <= 1'b1;
            end else if (im100 < over97) begin
               over_ph_reg[p] <= 1'b0;
            end
         end
      end
   end

   assign low_cond = &low_ph_reg;
   assign high_cond = &high_ph_reg;
   assign over_cond = |over_ph_reg;
   assign band_cond = !low_cond && !high_cond;
   assign min_done = (min_cnt_reg >= min_time_reg);
   assign max_done = max_run_reg && (max_cnt_reg >= max_time_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Pick-up state machine, stepped one cycle after the comparators
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         start_cnt_reg <= '0;
         max_cnt_reg <= '0;
         min_cnt_reg <= '0;
         act_cnt_reg <= '0;
         max_run_reg <= 1'b0;
         min_run_reg <= 1'b0;
         low_prev_reg <= 1'b0;
      end else if (tick_d_reg) begin
         low_prev_reg <= low_cond;
         case (state_reg)
            ST_IDLE: begin
               max_cnt_reg <= '0;
               max_run_reg <= 1'b0;
               act_cnt_reg <= '0;
               if (!low_cond) begin
                  start_cnt_reg <= '0;
               end else if (start_cnt_reg >= start_delay_reg) begin
                  min_cnt_reg <= '0;
                  min_run_reg <= 1'b1;
                  state_reg <= block_in ? ST_BLOCKED : ST_ACTIVE;
               end else begin
                  start_cnt_reg <= start_cnt_reg + 1'b1;
               end
            end
            ST_ACTIVE: begin
               // Cleared here so the next start delay runs in full
               start_cnt_reg <= '0;
               if (~&act_cnt_reg) begin
                  act_cnt_reg <= act_cnt_reg + 1'b1;
               end
               if (over_cond || block_in) begin
                  state_reg <= ST_IDLE;
               end else if (max_done) begin
                  state_reg <= ST_IDLE;
               end else if (band_cond && min_done && !low_prev_reg) begin
                  // Band held past the minimum hold time releases the pick-up
                  state_reg <= ST_IDLE;
               end
               if (band_cond && low_prev_reg) begin
                  min_cnt_reg <= '0;
                  min_run_reg <= 1'b1;
               end else if (min_run_reg && !min_done) begin
                  min_cnt_reg <= min_cnt_reg + 1'b1;
               end
               if (high_cond && !max_run_reg) begin
                  max_run_reg <= 1'b1;
                  max_cnt_reg <= '0;
               end else if (max_run_reg && high_cond) begin
                  max_cnt_reg <= max_cnt_reg + 1'b1;
               end
            end
            ST_BLOCKED: begin
               if (!low_cond) begin
                  state_reg <= ST_IDLE;
                  start_cnt_reg <= '0;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Events, outputs and counters
   assign cond_vec = {state_reg == ST_BLOCKED, state_reg == ST_ACTIVE, over_cond,
                      band_cond, high_cond, low_cond};
   assign rise_vec = cond_vec & ~cond_prev_reg;
   assign fall_vec = ~cond_vec & cond_prev_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Reset state counts as normal load, so no false ON follows reset
         cond_prev_reg <= NE'(1) << clpt_pkg::EV_NORMAL;
         event_out <= '0;
         pickup_active_out <= 1'b0;
         blocked_out <= 1'b0;
      end else begin
         cond_prev_reg <= cond_vec;
         event_out.on <= rise_vec & mask_on_reg;
         event_out.off <= fall_vec & mask_off_reg;
         event_out.stamp <= time_stamp;
         pickup_active_out <= cond_vec[clpt_pkg::EV_PICKUP];
         blocked_out <= cond_vec[clpt_pkg::EV_BLOCK];
      end
   end

   // A clear in the same cycle as an increment restarts the count at one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_count_reg <= '0;
         blk_count_reg <= '0;
      end else begin
         if (rise_vec[clpt_pkg::EV_PICKUP]) begin
            act_count_reg <= clr_cnt_reg ? 32'h00000001 : act_count_reg + 32'h00000001;
         end else if (clr_cnt_reg) begin
            act_count_reg <= '0;
         end
         if (rise_vec[clpt_pkg::EV_BLOCK]) begin
            blk_count_reg <= clr_cnt_reg ? 32'h00000001 : blk_count_reg + 32'h00000001;
         end else if (clr_cnt_reg) begin
            blk_count_reg <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Operation record store
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rec_wptr_reg <= '0;
         rec_fill_reg <= '0;
      end else if (rise_vec[clpt_pkg::EV_PICKUP] || rise_vec[clpt_pkg::EV_BLOCK]) begin
         rec_wptr_reg <= (rec_wptr_reg == AW'(REC_DEPTH - 1)) ? '0 : rec_wptr_reg + 1'b1;
         if (rec_fill_reg != (AW + 1)'(REC_DEPTH)) begin
            rec_fill_reg <= rec_fill_reg + 1'b1;
         end
      end
   end

   // Array left without reset so it maps onto plain storage
   always_ff @(posedge pclk) begin
      if (rise_vec[clpt_pkg::EV_PICKUP] || rise_vec[clpt_pkg::EV_BLOCK]) begin
         rec_mem[rec_wptr_reg].stamp <= time_stamp;
         rec_mem[rec_wptr_reg].id <= rise_vec[clpt_pkg::EV_BLOCK] ?
            3'(clpt_pkg::EV_BLOCK) : 3'(clpt_pkg::EV_PICKUP);
         rec_mem[rec_wptr_reg].group <= setting_group;
         rec_mem[rec_wptr_reg].mag <= measured_magnitude.mag;
         rec_mem[rec_wptr_reg].to_act <= (start_delay_reg > start_cnt_reg) ?
            start_delay_reg - start_cnt_reg : '0;
         rec_mem[rec_wptr_reg].act_time <= act_cnt_reg;
         rec_mem[rec_wptr_reg].startup <= max_cnt_reg;
         rec_mem[rec_wptr_reg].reclaim <= min_cnt_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait-free access cycle, data prepared in setup
   assign setup_ph = psel && !penable;
   assign wr_en = psel && penable && pready && pwrite;
   assign rec_rd = (rec_sel_reg < AW'(REC_DEPTH)) ? rec_mem[rec_sel_reg] : '0;

   always_comb begin
      rd_data = 32'h00000000;
      addr_ok = 1'b1;
      if (paddr == clpt_pkg::CTRL_OFS) begin
         rd_data = 32'h00000000;
      end else if (paddr == clpt_pkg::LOW_THR_OFS) begin
         rd_data = 32'(low_thr_reg);
      end else if (paddr == clpt_pkg::HIGH_THR_OFS) begin
         rd_data = 32'(high_thr_reg);
      end else if (paddr == clpt_pkg::OVER_THR_OFS) begin
         rd_data = 32'(over_thr_reg);
      end else if (paddr == clpt_pkg::START_OFS) begin
         rd_data = 32'(start_delay_reg);
      end else if (paddr == clpt_pkg::MAX_OFS) begin
         rd_data = 32'(max_time_reg);
      end else if (paddr == clpt_pkg::MIN_OFS) begin
         rd_data = 32'(min_time_reg);
      end else if (paddr == clpt_pkg::EVMASK_OFS) begin
         rd_data = {16'h0000, 2'h0, mask_off_reg, 2'h0, mask_on_reg};
      end else if (paddr == clpt_pkg::STATUS_OFS) begin
         rd_data = {24'h000000, state_reg, cond_vec};
      end else if (paddr == clpt_pkg::ACT_CNT_OFS) begin
         rd_data = act_count_reg;
      end else if (paddr == clpt_pkg::BLK_CNT_OFS) begin
         rd_data = blk_count_reg;
      end else if (paddr == clpt_pkg::REC_SEL_OFS) begin
         rd_data = 32'(rec_sel_reg);
      end else if (paddr == clpt_pkg::REC_PTR_OFS) begin
         rd_data = {23'h000000, rec_fill_reg, rec_wptr_reg};
      end else if (paddr == clpt_pkg::REC_TS_OFS) begin
         rd_data = rec_rd.stamp;
      end else if (paddr == clpt_pkg::REC_ID_OFS) begin
         rd_data = {24'h000000, 1'b0, rec_rd.group, 1'b0, rec_rd.id};
      end else if (paddr == clpt_pkg::REC_I12_OFS) begin
         rd_data = {rec_rd.mag[1], rec_rd.mag[0]};
      end else if (paddr == clpt_pkg::REC_I3_OFS) begin
         rd_data = 32'(rec_rd.mag[2]);
      end else if (paddr == clpt_pkg::REC_TTA_OFS) begin
         rd_data = 32'(rec_rd.to_act);
      end else if (paddr == clpt_pkg::REC_ACT_OFS) begin
         rd_data = 32'(rec_rd.act_time);
      end else if (paddr == clpt_pkg::REC_START_OFS) begin
         rd_data = 32'(rec_rd.startup);
      end else if (paddr == clpt_pkg::REC_RECL_OFS) begin
         rd_data = 32'(rec_rd.reclaim);
      end else begin
         addr_ok = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup_ph;
         pslverr <= setup_ph && !addr_ok;
         prdata <= (setup_ph && !pwrite) ? rd_data : 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_thr_reg <= clpt_pkg::LOW_DEF;
         high_thr_reg <= clpt_pkg::HIGH_DEF;
         over_thr_reg <= clpt_pkg::OVER_DEF;
         start_delay_reg <= clpt_pkg::START_DEF;
         max_time_reg <= clpt_pkg::MAX_DEF;
         min_time_reg <= clpt_pkg::MIN_DEF;
         mask_on_reg <= clpt_pkg::MASK_DEF;
         mask_off_reg <= clpt_pkg::MASK_DEF;
         rec_sel_reg <= '0;
         clr_cnt_reg <= 1'b0;
      end else begin
         clr_cnt_reg <= wr_en && (paddr == clpt_pkg::CTRL_OFS) &&
                        pwdata[clpt_pkg::CTRL_CLR_BIT];
         if (wr_en) begin
            if (paddr == clpt_pkg::LOW_THR_OFS) begin
               low_thr_reg <= pwdata[CW-1:0];
            end else if (paddr == clpt_pkg::HIGH_THR_OFS) begin
               high_thr_reg <= pwdata[CW-1:0];
            end else if (paddr == clpt_pkg::OVER_THR_OFS) begin
               over_thr_reg <= pwdata[CW-1:0];
            end else if (paddr == clpt_pkg::START_OFS) begin
               start_delay_reg <= pwdata[TW-1:0];
            end else if (paddr == clpt_pkg::MAX_OFS) begin
               max_time_reg <= pwdata[TW-1:0];
            end else if (paddr == clpt_pkg::MIN_OFS) begin
               min_time_reg <= pwdata[TW-1:0];
            end else if (paddr == clpt_pkg::EVMASK_OFS) begin
               mask_on_reg <= pwdata[NE-1:0];
               mask_off_reg <= pwdata[clpt_pkg::EVMASK_OFF_LSB +: NE];
            end else if (paddr == clpt_pkg::REC_SEL_OFS) begin
               rec_sel_reg <= pwdata[AW-1:0];
            end
         end
      end
   end

endmodule : clpt_cold_load_pickup

/* File: clpt_monitor.sv */
/*
 Port checker of the cold load pick-up block, bound to its top module.
 Assumes default thresholds and the tick length handed on by the bind.
*/
`timescale 1ns/10ps
module clpt_monitor #(
   parameter int TICK_CYCLES = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   input wire clpt_pkg::clpt_phase_t measured_magnitude,
   input wire logic pickup_active_out,
   input wire logic blocked_out,
   input wire clpt_pkg::clpt_event_t event_out
);
   localparam int WIN = 2 * TICK_CYCLES + 3;
   logic all_low;
   logic any_over;
   assign all_low = (measured_magnitude.mag[0] < 16'h0014)
      && (measured_magnitude.mag[1] < 16'h0014) && (measured_magnitude.mag[2] < 16'h0014);
   assign any_over = (measured_magnitude.mag[0] > 16'h00c8)
      || (measured_magnitude.mag[1] > 16'h00c8) || (measured_magnitude.mag[2] > 16'h00c8);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////////
   apb_wait_a: assert property (psel && !penable |=> pready) else $error("pready late");
   err_qual_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
   rd_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
   rise_low_a: assert property ($rose(pickup_active_out) |-> all_low)
      else $error("pick-up without low current");
   hold_min_a: assert property ($rose(pickup_active_out) |-> pickup_active_out [*8])
      else $error("pick-up too short");
   over_rel_a: assert property (pickup_active_out && any_over |-> ##[1:WIN] !pickup_active_out)
      else $error("overcurrent kept pick-up");
   rise_ev_a: assert property ($rose(pickup_active_out) |-> ##[0:3] event_out.on[4])
      else $error("no activation ON event");
   fall_ev_a: assert property ($fell(pickup_active_out) |-> ##[0:3] event_out.off[4])
      else $error("no activation OFF event");
   blk_excl_a: assert property (blocked_out |-> !pickup_active_out)
      else $error("blocked and active together");
   ev_pulse_a: assert property (event_out.on[4] |=> !event_out.on[4])
      else $error("event longer than one cycle");
   cover property ($rose(pickup_active_out));
   cover property ($rose(blocked_out));
   cover property (pslverr);
endmodule : clpt_monitor

bind clpt_cold_load_pickup clpt_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .prdata(prdata), .measured_magnitude(measured_magnitude),
   .pickup_active_out(pickup_active_out), .blocked_out(blocked_out), .event_out(event_out));

/* File: clpt_meas_model.sv */
/*
 Measurement chain and blocking source in front of the pick-up block.
 Assumes a level code from the bench: 0 low, 1 band, 2 high, 3 over.
*/
`timescale 1ns/10ps
module clpt_meas_model (
   input wire logic pclk,
   input wire logic [1:0] level,
   input wire logic [8:0] jit,
   input wire logic blk,
   output clpt_pkg::clpt_phase_t mag,
   output logic block
);
   // Bases clear of the 97 percent release band of the defaults
   localparam logic [3:0][15:0] BASE = {16'h00fa, 16'h0096, 16'h0032, 16'h0005};
   always_ff @(posedge pclk) begin
      for (int k = 0; k < 3; k++) begin
         mag.mag[k] <= BASE[level] + 16'(jit[3*k +: 3]);
      end
      block <= blk;
   end
endmodule : clpt_meas_model

/* File: tb_top.sv */
/*
 Self-checking bench of the cold load pick-up block.
 Assumes a ten-cycle timer tick and the register map of the package.
*/
`timescale 1ns/10ps
module tb_top;
   localparam int TK = 10;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   clpt_pkg::clpt_phase_t mag;
   logic block_in;
   logic pickup;
   logic blocked;
   logic blk = 1'b0;
   logic [1:0] level = 2'h1;
   logic [8:0] jit = 9'h000;
   logic [2:0] grp = 3'h0;
   logic [31:0] stamp = 32'h0;
   logic [33:0] exp_q[$];
   logic [33:0] sb_e;
   logic [31:0] seed = 32'h3c7a;
   int n_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   always #20 pclk = ~pclk;
   clpt_meas_model u_meas (.pclk(pclk), .level(level), .jit(jit), .blk(blk), .mag(mag),
      .block(block_in));
   clpt_cold_load_pickup #(.TICK_CYCLES(TK)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .measured_magnitude(mag), .block_in(block_in),
      .setting_group(grp), .time_stamp(stamp), .pickup_active_out(pickup),
      .blocked_out(blocked), .event_out());
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic close_out();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out
   // Reads note the expected data; writes only the expected error flag
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic er);
      @(posedge pclk);
      exp_q.push_back({wr, er, d});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wr ? d : 32'h0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic go(input logic [1:0] l, input logic b);
      @(posedge pclk);
      level <= l;
      blk <= b;
      jit <= 9'(rnd());
      grp <= 3'(rnd());
   endtask : go
   // Cycles from the level change until the watched output reaches v
   task automatic wt(input string nm, input logic sb, input logic v, input int lo, input int hi);
      int k;
      k = 0;
      while ((sb ? blocked : pickup) !== v && k <= hi) begin
         @(negedge pclk);
         k++;
      end
      chk(nm, 32'h1, 32'(k >= lo && k <= hi));
   endtask : wt
   task automatic act();
      go(2'h0, 1'b0);
      wt("rise", 1'b0, 1'b1, 3 * TK, 5 * TK + 5);
   endtask : act
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge pclk) begin
      stamp <= stamp + 32'h1;
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_errors++;
         close_out();
      end
   end
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         sb_e = exp_q.pop_front();
         chk("pslverr", {31'h0, sb_e[32]}, {31'h0, pslverr});
         if (!sb_e[33]) begin
            chk("prdata", sb_e[31:0], prdata);
         end
      end
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, clpt_pkg::START_OFS, 32'h3, 1'b0);
      apb(1'b1, clpt_pkg::MAX_OFS, 32'h6, 1'b0);
      apb(1'b1, clpt_pkg::MIN_OFS, 32'h4, 1'b0);
      apb(1'b0, clpt_pkg::START_OFS, 32'h3, 1'b0);
      apb(1'b0, 8'hfc, 32'h0, 1'b1);
      go(2'h0, 1'b0);
      repeat (15) @(posedge pclk);
      go(2'h1, 1'b0);
      repeat (6 * TK) @(posedge pclk);
      chk("early", 32'h0, {31'h0, pickup});
      apb(1'b0, clpt_pkg::ACT_CNT_OFS, 32'h0, 1'b0);
      $display("short dip done");
      act();
      go(2'h1, 1'b0);
      wt("reclaim", 1'b0, 1'b0, 3 * TK, 6 * TK);
      apb(1'b0, clpt_pkg::ACT_CNT_OFS, 32'h1, 1'b0);
      $display("reclaim done");
      act();
      go(2'h1, 1'b0);
      repeat (TK) @(posedge pclk);
      go(2'h2, 1'b0);
      wt("max", 1'b0, 1'b0, 5 * TK, 8 * TK);
      $display("inrush done");
      act();
      repeat (2 * TK) @(posedge pclk);
      go(2'h3, 1'b0);
      wt("over", 1'b0, 1'b0, 1, 2 * TK + 5);
      $display("overcurrent done");
      go(2'h0, 1'b1);
      wt("block", 1'b1, 1'b1, 3 * TK, 5 * TK + 5);
      chk("blocked", 32'h0, {31'h0, pickup});
      go(2'h1, 1'b0);
      repeat (TK) @(posedge pclk);
      apb(1'b0, clpt_pkg::BLK_CNT_OFS, 32'h1, 1'b0);
      $display("block done");
      apb(1'b1, clpt_pkg::START_OFS, 32'h0, 1'b0);
      go(2'h0, 1'b0);
      wt("zero", 1'b0, 1'b1, 1, 2 * TK + 5);
      go(2'h1, 1'b0);
      wt("release", 1'b0, 1'b0, 3 * TK, 6 * TK);
      apb(1'b0, clpt_pkg::ACT_CNT_OFS, 32'h4, 1'b0);
      apb(1'b1, clpt_pkg::CTRL_OFS, 32'h1, 1'b0);
      apb(1'b0, clpt_pkg::ACT_CNT_OFS, 32'h0, 1'b0);
      apb(1'b0, clpt_pkg::BLK_CNT_OFS, 32'h0, 1'b0);
      apb(1'b0, clpt_pkg::REC_PTR_OFS, 32'h55, 1'b0);
      apb(1'b0, clpt_pkg::REC_TTA_OFS, 32'h0, 1'b0);
      $display("counters done");
      close_out();
   end
endmodule : tb_top
